//--- inc/ddc_bind_pkg.sv
package ddc_bind_pkg;
   // bus and datapath widths
   localparam int ADDR_W    = 12;
   localparam int DATA_W    = 8;
   localparam int SAMPLE_W  = 12;
   localparam int MAG_W     = 8;
   localparam int FREQ_W    = 32;
   localparam int PHASE_W   = 16;
   localparam int PRESETS   = 4;
   localparam int SEL_W     = 2;
   localparam int OVERRANGE_PULSE_EXTENSION_W   = 3;
   localparam int STRETCH_W = 11;

   // register offsets
   localparam logic [ADDR_W-1:0] OFS_THRESH0  = 12'h211;
   localparam logic [ADDR_W-1:0] OFS_THRESH1  = 12'h212;
   localparam logic [ADDR_W-1:0] OFS_OVERRANGE_OUTPUT_CONFIG  = 12'h213;
   localparam logic [ADDR_W-1:0] OFS_SRC_MODE = 12'h214;
   localparam logic [ADDR_W-1:0] OFS_PRE_SEL  = 12'h215;
   localparam logic [ADDR_W-1:0] OFS_ROUTING  = 12'h216;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 12'h21a;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 12'h21b;

   // reset values
   localparam logic [DATA_W-1:0] RST_THRESH0  = 8'hf2;
   localparam logic [DATA_W-1:0] RST_THRESH1  = 8'hab;
   localparam logic [DATA_W-1:0] RST_OVERRANGE_OUTPUT_CONFIG  = 8'h07;
   localparam logic [DATA_W-1:0] RST_SRC_MODE = 8'h00;
   localparam logic [DATA_W-1:0] RST_PRE_SEL  = 8'h00;
   localparam logic [DATA_W-1:0] RST_ROUTING  = 8'h02;
   localparam logic [DATA_W-1:0] RST_IRQ      = 8'h00;

   // field positions
   localparam int OVERRANGE_PIN_ENABLE_BIT    = 3;
   localparam int OVERRANGE_PULSE_EXTENSION_LSB     = 0;
   localparam int SRC_MODE_LSB  = 0;
   localparam int SEL_A_LSB     = 0;
   localparam int SEL_B_LSB     = 2;
   localparam int ROUTE_A_BIT   = 0;
   localparam int ROUTE_B_BIT   = 1;
   localparam int IRQ_EVENTS    = 4;

   // writable field masks, reserved bits read back as zero
   localparam logic [DATA_W-1:0] MASK_IRQ = 8'h0f;

   // stretch length base, in device clock cycles
   localparam int OVR_BASE_CYCLES = 8;

   // preset source modes
   typedef enum logic [1:0] {
      SRC_REGISTER    = 2'h0,
      SRC_PINS_SPLIT  = 2'h1,
      SRC_PINS_SHARED = 2'h2,
      SRC_RESERVED    = 2'h3
   } preset_src_t;
endpackage

//--- hw/overrange_stretch.sv
`timescale 1ns/10ps
`default_nettype none
module overrange_stretch
   import ddc_bind_pkg::*;
(
   // clock and reset
   input  wire logic               core_clk,
   input  wire logic               sys_rst,
   // detection and extension
   input  wire logic               detect,
   input  wire logic [OVERRANGE_PULSE_EXTENSION_W-1:0] ext_sel,
   output logic                    pulse_ff
);
   logic [STRETCH_W-1:0] cnt_ff;   // cycles left after this one
   logic [STRETCH_W-1:0] nxt_len;  // full pulse length

   // length is 8 shifted by the extension field
   assign nxt_len = STRETCH_W'(OVR_BASE_CYCLES) << ext_sel;

   // pulse and down counter, a fresh detection reloads the count
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pulse_ff <= 1'b0;
         cnt_ff   <= '0;
      end else if (detect) begin
         pulse_ff <= 1'b1;
         cnt_ff   <= nxt_len - STRETCH_W'(1);
      end else if (pulse_ff) begin
         if (cnt_ff == '0) begin
            pulse_ff <= 1'b0;
         end else begin
            cnt_ff <= cnt_ff - STRETCH_W'(1);
         end
      end
   end

   property p_min_pulse;
      @(posedge core_clk) disable iff (sys_rst)
         $rose(pulse_ff) |-> pulse_ff [*8];
   endproperty
   a_min_pulse: assert property (p_min_pulse) else $error("pulse shorter than 8");

   property p_restart;
      @(posedge core_clk) disable iff (sys_rst)
         detect |=> pulse_ff && cnt_ff == $past(nxt_len) - STRETCH_W'(1);
   endproperty
   a_restart: assert property (p_restart) else $error("count not reloaded");
endmodule
`default_nettype wire

//--- hw/preset_mux.sv
`timescale 1ns/10ps
`default_nettype none
module preset_mux
   import ddc_bind_pkg::*;
(
   // clock and reset
   input  wire logic               core_clk,
   input  wire logic               sys_rst,
   // selection
   input  wire logic [SEL_W-1:0]   sel,
   // preset banks
   input  wire logic [FREQ_W-1:0]  freq_presets  [PRESETS],
   input  wire logic [PHASE_W-1:0] phase_presets [PRESETS],
   // active setting
   output logic      [FREQ_W-1:0]  freq_ff,
   output logic      [PHASE_W-1:0] phase_ff
);
   // whole word pair changes on one edge, never half of it
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         freq_ff  <= '0;
         phase_ff <= '0;
      end else begin
         freq_ff  <= freq_presets[sel];
         phase_ff <= phase_presets[sel];
      end
   end

   property p_active_preset;
      @(posedge core_clk) disable iff (sys_rst)
         1'b1 |=> freq_ff == freq_presets[$past(sel)] && phase_ff == phase_presets[$past(sel)];
   endproperty
   a_active_preset: assert property (p_active_preset) else $error("wrong preset");
endmodule
`default_nettype wire

//--- hw/ddc_preset_overrange_binding.sv
// What this block does
// - over-range pins forced low unless enabled
// - enable gates pins only, not link bits
// - pin pulse lasts at least 8 times 2^n
// - four presets per converter supply frequency, phase
// - mode 0: register fields select both presets
// - mode 1: A pins to A, B to B
// - mode 2: A pins pick both; 3 reserved
// - single channel uses converter A's method
// - field 3:2 picks B, ignored single channel
// - field 1:0 picks A preset n
// - routing bit 1 sources digital channel B
// - routing bit 0 sources digital channel A
// - digital channel down when its source down
// - I magnitude at threshold 0 sets bit 0
// - Q magnitude at threshold 1 sets bit 1
`timescale 1ns/10ps
`default_nettype none
module ddc_preset_overrange_binding
   import ddc_bind_pkg::*;
(
   // clock and reset
   input  wire logic                core_clk,
   input  wire logic                sys_rst,
   // register port
   input  wire logic [ADDR_W-1:0]   reg_addr,
   input  wire logic [DATA_W-1:0]   reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic      [DATA_W-1:0]   reg_rdata_ff,
   // interrupt
   output logic                     irq_ff,
   // device mode and power
   input  wire logic                single_channel,
   input  wire logic                analog_a_powerdown,
   input  wire logic                analog_b_powerdown,
   output logic                     dig_a_powerdown_ff,
   output logic                     dig_b_powerdown_ff,
   // converter samples
   input  wire logic [SAMPLE_W-1:0] adc_a_sample,
   input  wire logic [SAMPLE_W-1:0] adc_b_sample,
   output logic      [SAMPLE_W-1:0] dig_a_sample_ff,
   output logic      [SAMPLE_W-1:0] dig_b_sample_ff,
   // down-converter output magnitudes
   input  wire logic [MAG_W-1:0]    ddc_a_i_mag,
   input  wire logic [MAG_W-1:0]    ddc_a_q_mag,
   input  wire logic [MAG_W-1:0]    ddc_b_i_mag,
   input  wire logic [MAG_W-1:0]    ddc_b_q_mag,
   // over-range control bits to the serial link
   output logic      [1:0]          link_ovr_a_ff,
   output logic      [1:0]          link_ovr_b_ff,
   // over-range pins
   output logic                     overrange_a_bit0_pin,
   output logic                     overrange_a_bit1_pin,
   output logic                     overrange_b_bit0_pin,
   output logic                     overrange_b_bit1_pin,
   // preset select pins
   input  wire logic [SEL_W-1:0]    preset_pins_a,
   input  wire logic [SEL_W-1:0]    preset_pins_b,
   // preset banks
   input  wire logic [FREQ_W-1:0]   oscillator_frequency_a_preset [PRESETS],
   input  wire logic [PHASE_W-1:0]  oscillator_phase_a_preset     [PRESETS],
   input  wire logic [FREQ_W-1:0]   oscillator_frequency_b_preset [PRESETS],
   input  wire logic [PHASE_W-1:0]  oscillator_phase_b_preset     [PRESETS],
   // active preset index and setting
   output logic      [SEL_W-1:0]    active_preset_a_ff,
   output logic      [SEL_W-1:0]    active_preset_b_ff,
   output logic      [FREQ_W-1:0]   active_freq_a_ff,
   output logic      [PHASE_W-1:0]  active_phase_a_ff,
   output logic      [FREQ_W-1:0]   active_freq_b_ff,
   output logic      [PHASE_W-1:0]  active_phase_b_ff
);
   // software registers
   logic [DATA_W-1:0] thresh0_ff;                // threshold 0
   logic [DATA_W-1:0] thresh1_ff;                // threshold 1
   logic [DATA_W-1:0] overrange_output_config;   // pin enable and extension
   logic [DATA_W-1:0] nco_preset_source_mode;    // preset source
   logic [DATA_W-1:0] nco_preset_select;         // register select fields
   logic [DATA_W-1:0] digital_channel_routing;   // channel binding
   logic [DATA_W-1:0] irq_stat_ff;               // sticky events
   logic [DATA_W-1:0] irq_mask_ff;               // event enables

   // decoded fields
   logic                overrange_pin_enable;
   logic [OVERRANGE_PULSE_EXTENSION_W-1:0]  overrange_pulse_extension;
   preset_src_t         src_mode;
   logic [SEL_W-1:0]    preset_select_a;
   logic [SEL_W-1:0]    preset_select_b;

   // detection path
   logic [3:0]          nxt_ovr;        // a0 a1 b0 b1 compare results
   logic [3:0]          ovr_ff;         // registered control bits
   logic [3:0]          stretch;        // stretched pulses
   logic [3:0]          pin_ff;         // gated pins
   logic [3:0]          ovr_rise;       // new over-range event
   logic [3:0]          ovr_prev_ff;    // control bits one cycle back

   // preset selection
   logic [SEL_W-1:0]    nxt_sel_a;
   logic [SEL_W-1:0]    nxt_sel_b;

   // bus decode
   logic                stat_rd;

   assign overrange_pin_enable      = overrange_output_config[OVERRANGE_PIN_ENABLE_BIT];
   assign overrange_pulse_extension = overrange_output_config[OVERRANGE_PULSE_EXTENSION_LSB +: OVERRANGE_PULSE_EXTENSION_W];
   assign src_mode        = preset_src_t'(nco_preset_source_mode[SRC_MODE_LSB +: 2]);
   assign preset_select_a = nco_preset_select[SEL_A_LSB +: SEL_W];
   assign preset_select_b = nco_preset_select[SEL_B_LSB +: SEL_W];
   assign stat_rd         = reg_rd && reg_addr == OFS_IRQ_STAT;

   // register writes, full bytes kept except the interrupt mask
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         thresh0_ff              <= RST_THRESH0;
         thresh1_ff              <= RST_THRESH1;
         overrange_output_config <= RST_OVERRANGE_OUTPUT_CONFIG;
         nco_preset_source_mode  <= RST_SRC_MODE;
         nco_preset_select       <= RST_PRE_SEL;
         digital_channel_routing <= RST_ROUTING;
         irq_mask_ff             <= RST_IRQ;
      end else if (reg_wr) begin
         unique case (reg_addr)
            OFS_THRESH0:  thresh0_ff              <= reg_wdata;
            OFS_THRESH1:  thresh1_ff              <= reg_wdata;
            OFS_OVERRANGE_OUTPUT_CONFIG:  overrange_output_config <= reg_wdata;
            OFS_SRC_MODE: nco_preset_source_mode  <= reg_wdata;
            OFS_PRE_SEL:  nco_preset_select       <= reg_wdata;
            OFS_ROUTING:  digital_channel_routing <= reg_wdata;
            OFS_IRQ_MASK: irq_mask_ff             <= reg_wdata & MASK_IRQ;
            default: begin
               // unmapped write is dropped
            end
         endcase
      end
   end

   // read data, one cycle after the strobe, zero elsewhere
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         reg_rdata_ff <= '0;
      end else if (reg_rd) begin
         unique case (reg_addr)
            OFS_THRESH0:  reg_rdata_ff <= thresh0_ff;
            OFS_THRESH1:  reg_rdata_ff <= thresh1_ff;
            OFS_OVERRANGE_OUTPUT_CONFIG:  reg_rdata_ff <= overrange_output_config;
            OFS_SRC_MODE: reg_rdata_ff <= nco_preset_source_mode;
            OFS_PRE_SEL:  reg_rdata_ff <= nco_preset_select;
            OFS_ROUTING:  reg_rdata_ff <= digital_channel_routing;
            OFS_IRQ_STAT: reg_rdata_ff <= irq_stat_ff;
            OFS_IRQ_MASK: reg_rdata_ff <= irq_mask_ff;
            default:      reg_rdata_ff <= '0;
         endcase
      end else begin
         reg_rdata_ff <= '0;
      end
   end

   // threshold compares on I and Q magnitudes
   always_comb begin
      nxt_ovr[0] = ddc_a_i_mag >= thresh0_ff;
      nxt_ovr[1] = ddc_a_q_mag >= thresh1_ff;
      nxt_ovr[2] = ddc_b_i_mag >= thresh0_ff;
      nxt_ovr[3] = ddc_b_q_mag >= thresh1_ff;
   end

   // control bits run to the link whatever the pin enable says
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ovr_ff <= '0;
      end else begin
         ovr_ff <= nxt_ovr;
      end
   end

   assign link_ovr_a_ff = ovr_ff[1:0];
   assign link_ovr_b_ff = ovr_ff[3:2];
   assign ovr_rise      = ovr_ff & ~ovr_prev_ff;

   // previous control bits for edge detection
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ovr_prev_ff <= '0;
      end else begin
         ovr_prev_ff <= ovr_ff;
      end
   end

   // one stretcher per pin
   for (genvar g = 0; g < 4; g++) begin : g_stretch
      overrange_stretch u_stretch (
         .core_clk (core_clk),
         .sys_rst  (sys_rst),
         .detect   (ovr_ff[g]),
         .ext_sel  (overrange_pulse_extension),
         .pulse_ff (stretch[g])
      );
   end

   // pins held low while disabled
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pin_ff <= '0;
      end else begin
         pin_ff <= stretch & {4{overrange_pin_enable}};
      end
   end

   assign overrange_a_bit0_pin = pin_ff[0];
   assign overrange_a_bit1_pin = pin_ff[1];
   assign overrange_b_bit0_pin = pin_ff[2];
   assign overrange_b_bit1_pin = pin_ff[3];

   // sticky status, a new event beats the read clear
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         irq_stat_ff <= RST_IRQ;
      end else begin
         irq_stat_ff <= ((stat_rd ? '0 : irq_stat_ff) | DATA_W'(ovr_rise)) & MASK_IRQ;
      end
   end

   // level interrupt from unmasked status
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(irq_stat_ff & irq_mask_ff);
      end
   end

   // preset source selection
   always_comb begin
      unique case (src_mode)
         SRC_PINS_SPLIT: begin
            nxt_sel_a = preset_pins_a;
            nxt_sel_b = preset_pins_b;
         end
         SRC_PINS_SHARED: begin
            nxt_sel_a = preset_pins_a;
            nxt_sel_b = preset_pins_a;
         end
         default: begin
            // register fields; reserved mode behaves the same
            nxt_sel_a = preset_select_a;
            nxt_sel_b = preset_select_b;
         end
      endcase
      if (single_channel) begin
         nxt_sel_b = nxt_sel_a;
      end
   end

   // active index registered on the device clock
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         active_preset_a_ff <= '0;
         active_preset_b_ff <= '0;
      end else begin
         active_preset_a_ff <= nxt_sel_a;
         active_preset_b_ff <= nxt_sel_b;
      end
   end

   preset_mux u_mux_a (
      .core_clk      (core_clk),
      .sys_rst       (sys_rst),
      .sel           (active_preset_a_ff),
      .freq_presets  (oscillator_frequency_a_preset),
      .phase_presets (oscillator_phase_a_preset),
      .freq_ff       (active_freq_a_ff),
      .phase_ff      (active_phase_a_ff)
   );

   preset_mux u_mux_b (
      .core_clk      (core_clk),
      .sys_rst       (sys_rst),
      .sel           (active_preset_b_ff),
      .freq_presets  (oscillator_frequency_b_preset),
      .phase_presets (oscillator_phase_b_preset),
      .freq_ff       (active_freq_b_ff),
      .phase_ff      (active_phase_b_ff)
   );

   // channel routing and power coupling
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         dig_a_sample_ff    <= '0;
         dig_b_sample_ff    <= '0;
         dig_a_powerdown_ff <= 1'b0;
         dig_b_powerdown_ff <= 1'b0;
      end else begin
         dig_a_sample_ff <= digital_channel_routing[ROUTE_A_BIT] ? adc_b_sample
                                                                 : adc_a_sample;
         dig_b_sample_ff <= digital_channel_routing[ROUTE_B_BIT] ? adc_b_sample
                                                                 : adc_a_sample;
         dig_a_powerdown_ff <= digital_channel_routing[ROUTE_A_BIT] ? analog_b_powerdown
                                                                    : analog_a_powerdown;
         dig_b_powerdown_ff <= digital_channel_routing[ROUTE_B_BIT] ? analog_b_powerdown
                                                                    : analog_a_powerdown;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   property p_pins_off;
      !overrange_pin_enable |=> pin_ff == 4'h0;
   endproperty
   a_pins_off: assert property (p_pins_off) else $error("pin high while disabled");

   property p_link_bits;
      nxt_ovr[0] && !overrange_pin_enable |=> link_ovr_a_ff[0];
   endproperty
   a_link_bits: assert property (p_link_bits) else $error("link bit gated");

   sequence s_hit_a_i;
      ddc_a_i_mag >= thresh0_ff && overrange_pin_enable;
   endsequence
   sequence s_pin_a0_up;
      ##3 overrange_a_bit0_pin;
   endsequence
   property p_thresh0;
      s_hit_a_i ##0 (overrange_pin_enable [*3]) |-> ##0 1'b1 ##0 s_pin_a0_up;
   endproperty
   a_thresh0: assert property (p_thresh0) else $error("threshold 0 missed");

   property p_thresh1;
      ddc_b_q_mag >= thresh1_ff |=> link_ovr_b_ff[1];
   endproperty
   a_thresh1: assert property (p_thresh1) else $error("threshold 1 missed");

   property p_mode_reg;
      src_mode == SRC_REGISTER && !single_channel
         |=> active_preset_a_ff == $past(preset_select_a)
             && active_preset_b_ff == $past(preset_select_b);
   endproperty
   a_mode_reg: assert property (p_mode_reg) else $error("register select ignored");

   property p_mode_split;
      src_mode == SRC_PINS_SPLIT && !single_channel
         |=> active_preset_b_ff == $past(preset_pins_b);
   endproperty
   a_mode_split: assert property (p_mode_split) else $error("B pins ignored");

   property p_mode_shared;
      src_mode == SRC_PINS_SHARED |=> active_preset_b_ff == $past(preset_pins_a);
   endproperty
   a_mode_shared: assert property (p_mode_shared) else $error("shared pins ignored");

   property p_single;
      single_channel |=> active_preset_b_ff == active_preset_a_ff;
   endproperty
   a_single: assert property (p_single) else $error("single channel preset split");

   property p_route;
      1'b1 |=> dig_b_sample_ff == ($past(digital_channel_routing[ROUTE_B_BIT])
                                   ? $past(adc_b_sample) : $past(adc_a_sample));
   endproperty
   a_route: assert property (p_route) else $error("channel B misrouted");

   property p_power;
      !digital_channel_routing[ROUTE_A_BIT] && analog_a_powerdown |=> dig_a_powerdown_ff;
   endproperty
   a_power: assert property (p_power) else $error("channel A not powered down");
endmodule
`default_nettype wire

//--- bench/host_partner.sv
`timescale 1ns/10ps
`default_nettype none
module host_partner
   import ddc_bind_pkg::*;
(
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             sys_rst,
   // select values wanted by the host
   input  wire logic [SEL_W-1:0] want_a,
   input  wire logic [SEL_W-1:0] want_b,
   output logic      [SEL_W-1:0] preset_pins_a,
   output logic      [SEL_W-1:0] preset_pins_b,
   // over-range pin watch
   input  wire logic             overrange_pin,
   output logic      [7:0]       width_ff,
   output logic      [7:0]       runs_ff
);
   logic [7:0] run_ff; // high cycles in the current run
   // host logic moves its select pins only on the clock edge
   always_ff @(posedge core_clk) begin
      preset_pins_a <= want_a;
      preset_pins_b <= want_b;
   end
   // length and number of high runs of the watched pin
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         run_ff   <= 8'h00;
         width_ff <= 8'h00;
         runs_ff  <= 8'h00;
      end else if (overrange_pin) begin
         run_ff <= run_ff + 8'h01;
      end else if (run_ff != 8'h00) begin
         width_ff <= run_ff;
         runs_ff  <= runs_ff + 8'h01;
         run_ff   <= 8'h00;
      end
   end
endmodule
`default_nettype wire

//--- bench/ddc_preset_overrange_binding_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module ddc_preset_overrange_binding_bench
   import ddc_bind_pkg::*;
;
   logic                core_clk, sys_rst, reg_wr, reg_rd, irq, rd_seen, seen;
   logic [ADDR_W-1:0]   reg_addr;
   logic [DATA_W-1:0]   reg_wdata, rdata, ev, sel;
   logic                single_channel, pd_a, pd_b, dpd_a, dpd_b;
   logic [SAMPLE_W-1:0] smp_a, smp_b, dig_a, dig_b;
   logic [MAG_W-1:0]    mag [4];     // a_i, a_q, b_i, b_q
   logic [1:0]          lk_a, lk_b;  // link control bits
   logic [3:0]          pin;         // over-range pins
   logic [SEL_W-1:0]    want_a, want_b, pn_a, pn_b, act_a, act_b, ea, eb;
   logic [FREQ_W-1:0]   fq_a [PRESETS], fq_b [PRESETS], f_a, f_b;
   logic [PHASE_W-1:0]  ph_a [PRESETS], ph_b [PRESETS], p_a, p_b;
   logic [7:0]          width, runs;
   logic [DATA_W-1:0]   exp_q [$];   // expected read data, oldest first
   int                  n_fail, checked, seed;
   // reset table plus one unmapped address
   localparam logic [ADDR_W-1:0] RA [9] = '{OFS_THRESH0, OFS_THRESH1, OFS_OVERRANGE_OUTPUT_CONFIG, OFS_SRC_MODE,
      OFS_PRE_SEL, OFS_ROUTING, OFS_IRQ_STAT, OFS_IRQ_MASK, 12'h300};
   localparam logic [DATA_W-1:0] RV [9] = '{8'hf2, 8'hab, 8'h07, 8'h00, 8'h00, 8'h02, 8'h00,
      8'h00, 8'h00};

   ddc_preset_overrange_binding i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_ff(rdata), .irq_ff(irq), .single_channel(single_channel),
      .analog_a_powerdown(pd_a), .analog_b_powerdown(pd_b), .dig_a_powerdown_ff(dpd_a),
      .dig_b_powerdown_ff(dpd_b), .adc_a_sample(smp_a), .adc_b_sample(smp_b),
      .dig_a_sample_ff(dig_a), .dig_b_sample_ff(dig_b), .ddc_a_i_mag(mag[0]),
      .ddc_a_q_mag(mag[1]), .ddc_b_i_mag(mag[2]), .ddc_b_q_mag(mag[3]),
      .link_ovr_a_ff(lk_a), .link_ovr_b_ff(lk_b), .overrange_a_bit0_pin(pin[0]),
      .overrange_a_bit1_pin(pin[1]), .overrange_b_bit0_pin(pin[2]),
      .overrange_b_bit1_pin(pin[3]), .preset_pins_a(pn_a), .preset_pins_b(pn_b),
      .oscillator_frequency_a_preset(fq_a), .oscillator_phase_a_preset(ph_a),
      .oscillator_frequency_b_preset(fq_b), .oscillator_phase_b_preset(ph_b),
      .active_preset_a_ff(act_a), .active_preset_b_ff(act_b), .active_freq_a_ff(f_a),
      .active_phase_a_ff(p_a), .active_freq_b_ff(f_b), .active_phase_b_ff(p_b));

   host_partner i_host (.core_clk(core_clk), .sys_rst(sys_rst), .want_a(want_a),
      .want_b(want_b), .preset_pins_a(pn_a), .preset_pins_b(pn_b),
      .overrange_pin(pin[0]), .width_ff(width), .runs_ff(runs));

   // clock, 20 ns period
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // read data checker: takes the oldest note one cycle after each read
   always @(posedge core_clk) begin
      if (rd_seen) begin
         ev = exp_q.pop_front();
         `CHK(rdata, ev)
      end
      rd_seen <= reg_rd;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // one-cycle write, then a quiet edge so strobes never collide
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
   endtask
   // single-cycle magnitude hit, notes whether the link bit rose
   task automatic hit(input int k, input logic [MAG_W-1:0] m);
      mag[k] <= m;
      @(posedge core_clk);
      mag[k] <= 8'h00;
      seen = 1'b0;
      repeat (4) begin
         @(posedge core_clk);
         seen = seen | ((k == 0) ? lk_a[0] : lk_b[1]);
      end
   endtask
   task automatic conclude();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // watchdog, far beyond the expected run length
   initial begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      conclude();
   end

   // main sequence
   initial begin
      {sys_rst, reg_wr, reg_rd, rd_seen, single_channel, pd_a, pd_b} = 7'h41;
      {reg_addr, reg_wdata, smp_a, smp_b, want_a, want_b} = '0;
      mag = '{default: 8'h00};
      n_fail = 0;
      checked = 0;
      seed = 32'h8975eb2b;
      for (int k = 0; k < PRESETS; k++) begin
         fq_a[k] = 32'ha0000000 + 32'(k);
         fq_b[k] = 32'hb0000000 + 32'(k);
         ph_a[k] = 16'h0a00 + 16'(k);
         ph_b[k] = 16'h0b00 + 16'(k);
      end
      tick(8);
      sys_rst <= 1'b0;
      for (int i = 0; i < 9; i++) rd(RA[i], RV[i]);
      // every source mode, dual then single channel; routing stays default here
      for (int i = 0; i < 16; i++) begin
         sel = 8'($random(seed));
         want_a <= SEL_W'($random(seed));
         want_b <= SEL_W'($random(seed));
         single_channel <= i[3];
         wr(OFS_SRC_MODE, {6'h00, i[1:0]});
         wr(OFS_PRE_SEL, sel);
         tick(5);
         case (i[1:0])
            2'h1: begin ea = want_a; eb = want_b; end
            2'h2: begin ea = want_a; eb = want_a; end
            default: begin ea = sel[1:0]; eb = sel[3:2]; end
         endcase
         if (i[3]) eb = ea;
         `CHK(act_a, ea)
         `CHK(act_b, eb)
         `CHK(f_a, 32'ha0000000 + 32'(ea))
         `CHK(p_b, 16'h0b00 + 16'(eb))
         `CHK(f_b, 32'hb0000000 + 32'(eb))
         `CHK(p_a, 16'h0a00 + 16'(ea))
      end
      rd(OFS_PRE_SEL, sel);
      single_channel <= 1'b0;
      // each routing value; the link is idle here
      for (int r = 0; r < 4; r++) begin
         wr(OFS_ROUTING, 8'(r));
         smp_a <= SAMPLE_W'($random(seed));
         smp_b <= SAMPLE_W'($random(seed));
         pd_a <= 1'($random(seed));
         pd_b <= 1'($random(seed));
         tick(4);
         `CHK(dig_a, r[0] ? smp_b : smp_a)
         `CHK(dig_b, r[1] ? smp_b : smp_a)
         `CHK(dpd_a, r[0] ? pd_b : pd_a)
         `CHK(dpd_b, r[1] ? pd_b : pd_a)
         rd(OFS_ROUTING, 8'(r));
      end
      // pins disabled: link bit still fires at threshold, pin stays low
      wr(OFS_OVERRANGE_OUTPUT_CONFIG, 8'h00);
      hit(0, RST_THRESH0);
      `CHK(seen, 1'b1)
      tick(20);
      `CHK(runs, 8'h00)
      // enabled: one below threshold is no hit, then stretch lengths
      wr(OFS_OVERRANGE_OUTPUT_CONFIG, 8'h08);
      hit(0, RST_THRESH0 - 8'h01);
      `CHK(seen, 1'b0)
      hit(0, RST_THRESH0);
      tick(20);
      `CHK(width, 8'd8)
      wr(OFS_OVERRANGE_OUTPUT_CONFIG, 8'h09);
      hit(0, 8'hff);
      tick(30);
      `CHK(width, 8'd16)
      // second hit five cycles later reloads the count
      wr(OFS_OVERRANGE_OUTPUT_CONFIG, 8'h08);
      hit(0, 8'hff);
      hit(0, 8'hff);
      tick(20);
      `CHK(width, 8'd13)
      hit(3, RST_THRESH1);
      `CHK(seen, 1'b1)
      `CHK(pin, 4'h8)
      // sticky status, mask and clear on read
      `CHK(irq, 1'b0)
      wr(OFS_IRQ_MASK, 8'h08);
      tick(2);
      `CHK(irq, 1'b1)
      rd(OFS_IRQ_STAT, 8'h09);
      tick(2);
      `CHK(irq, 1'b0)
      rd(OFS_IRQ_STAT, 8'h00);
      tick(4);
      conclude();
   end
endmodule
`default_nettype wire
